// file: ilc_loop_code.v
// Purpose: T1 in-band loop code generator and three pattern detectors
// Assumes: bit strobes and data are synchronous to clk_i; Wishbone classic slave
// Notes: one clock domain, registered ack one cycle after the request
//
// Notes on behaviour
// - generator and detectors work only while T1 mode is selected
// - patterns may be 1 to 8 bits long, or exactly 16 bits
// - transmit length from control bits 7:6: 5, 6/3, 7, 16/8/4/2/1
// - pattern repeats continuously while the loop code transmit enable is set
// - F-bit replaces one pattern position every 193 bits unless insertion is off
// - bit 7 of first transmit byte goes first; low bits unused for short lengths
// - second transmit byte is the low byte of 16-bit codes only
// - three independent detectors: loop-up, loop-down and spare
// - loop-down length from control bits 2:0, 111 means 8 or 16
// - loop-up length from control bits 5:3, same encoding
// - both code bytes form a 16-bit code; same byte twice for 8 bits
// - first code byte bit 7 leads; trailing bits ignored for short lengths
// - second code byte ignored for lengths 1 to 7
// - detection tolerates bit errors near 1e-2, framed or unframed
// - writing a detector code byte restarts its integration period
// - after about 36 ms of valid code the matching status flag is set
`include "ilc_defines.vh"

module ilc_loop_code #(
  parameter INTEG_CYCLES = `ILC_INTEG_US * `ILC_CLK_MHZ
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire tx_bit_strobe_i,
  input wire tx_data_i,
  input wire tx_fbit_i,
  output reg tx_data_o,
  output reg tx_code_active_o,
  input wire rx_bit_strobe_i,
  input wire rx_data_i,
  output reg [2:0] code_detected_o,
  output reg irq_o
);

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [7:0] inband_code_control_ff;
  reg [7:0] tx_code_def_1_ff;
  reg [7:0] tx_code_def_2_ff;
  reg [7:0] rx_spare_length_control_ff;
  reg [7:0] t1_common_control_1_ff;
  reg [7:0] mode_ctrl_ff;
  reg [7:0] irq_stat_ff;
  reg [7:0] irq_en_ff;
  reg [7:0] det_code_1_ff [0:2];
  reg [7:0] det_code_2_ff [0:2];
  wire [2:0] det_flag;
  reg [2:0] det_flag_d_ff;

  wire [9:0] reg_idx = wb_adr_i[11:2];
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0] wr_byte = wb_dat_i[7:0];
  wire t1_mode = mode_ctrl_ff[`ILC_T1_MODE_BIT];
  wire fbit_ins = mode_ctrl_ff[`ILC_FBIT_INS_BIT];
  wire tx_enable = t1_common_control_1_ff[`ILC_TX_EN_BIT] & t1_mode;
  wire [7:0] status_3 = {det_flag, 5'h0_0};

  // per-detector length selects and restart strobes
  wire [2:0] det_len_sel [0:2];
  wire [2:0] det_restart;
  assign det_len_sel[0] = inband_code_control_ff[`ILC_UP_LEN_HI:`ILC_UP_LEN_LO];
  assign det_len_sel[1] = inband_code_control_ff[`ILC_DN_LEN_HI:`ILC_DN_LEN_LO];
  assign det_len_sel[2] = rx_spare_length_control_ff[`ILC_SP_LEN_HI:`ILC_SP_LEN_LO];
  // code byte writes restart integration
  assign det_restart[0] = bus_wr & ((reg_idx == `ILC_IDX_UP_DEF_1) |
                                    (reg_idx == `ILC_IDX_UP_DEF_2));
  assign det_restart[1] = bus_wr & ((reg_idx == `ILC_IDX_DN_DEF_1) |
                                    (reg_idx == `ILC_IDX_DN_DEF_2));
  assign det_restart[2] = bus_wr & ((reg_idx == `ILC_IDX_SP_DEF_1) |
                                    (reg_idx == `ILC_IDX_SP_DEF_2));

  // events: rising edge of any detected flag, in status bit layout
  wire [7:0] irq_event = {det_flag & ~det_flag_d_ff, 5'h0_0};
  wire [7:0] irq_clear = (bus_wr && reg_idx == `ILC_IDX_IRQ_CLR) ? wr_byte : 8'h00;

  // control register writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      inband_code_control_ff <= `ILC_RST_BYTE;
      tx_code_def_1_ff <= `ILC_RST_BYTE;
      tx_code_def_2_ff <= `ILC_RST_BYTE;
      rx_spare_length_control_ff <= `ILC_RST_BYTE;
      t1_common_control_1_ff <= `ILC_RST_BYTE;
      mode_ctrl_ff <= `ILC_RST_MODE;
      irq_en_ff <= `ILC_RST_BYTE;
    end
    else if (bus_wr)
    begin
      case (reg_idx)
        `ILC_IDX_INBAND_CTRL: inband_code_control_ff <= wr_byte;
        `ILC_IDX_TX_DEF_1: tx_code_def_1_ff <= wr_byte;
        `ILC_IDX_TX_DEF_2: tx_code_def_2_ff <= wr_byte;
        `ILC_IDX_SP_LEN: rx_spare_length_control_ff <= {5'h0_0, wr_byte[2:0]};
        `ILC_IDX_T1_CTRL: t1_common_control_1_ff <= {7'h0_0, wr_byte[0]};
        `ILC_IDX_MODE: mode_ctrl_ff <= {6'h0_0, wr_byte[1:0]};
        `ILC_IDX_IRQ_EN: irq_en_ff <= {wr_byte[7:5], 5'h0_0};
        default: inband_code_control_ff <= inband_code_control_ff;
      endcase
    end
  end

  // detector code bytes, one array entry per detector
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      det_code_1_ff[0] <= `ILC_RST_BYTE;
      det_code_1_ff[1] <= `ILC_RST_BYTE;
      det_code_1_ff[2] <= `ILC_RST_BYTE;
      det_code_2_ff[0] <= `ILC_RST_BYTE;
      det_code_2_ff[1] <= `ILC_RST_BYTE;
      det_code_2_ff[2] <= `ILC_RST_BYTE;
    end
    else if (bus_wr)
    begin
      case (reg_idx)
        `ILC_IDX_UP_DEF_1: det_code_1_ff[0] <= wr_byte;
        `ILC_IDX_UP_DEF_2: det_code_2_ff[0] <= wr_byte;
        `ILC_IDX_DN_DEF_1: det_code_1_ff[1] <= wr_byte;
        `ILC_IDX_DN_DEF_2: det_code_2_ff[1] <= wr_byte;
        `ILC_IDX_SP_DEF_1: det_code_1_ff[2] <= wr_byte;
        `ILC_IDX_SP_DEF_2: det_code_2_ff[2] <= wr_byte;
        default: det_code_1_ff[0] <= det_code_1_ff[0];
      endcase
    end
  end

  // sticky interrupt status; a new event wins over a clear
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_ff <= `ILC_RST_BYTE;
      det_flag_d_ff <= 3'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clear) | irq_event;
      det_flag_d_ff <= det_flag;
      irq_o <= |(((irq_stat_ff & ~irq_clear) | irq_event) & irq_en_ff);
    end
  end

  // ------------------------------------------------------------
  // wishbone read and acknowledge
  // ------------------------------------------------------------
  reg [7:0] rd_byte;

  // read mux, unmapped and write-only read as zero
  always @*
  begin
    rd_byte = 8'h00;
    case (reg_idx)
      `ILC_IDX_INBAND_CTRL: rd_byte = inband_code_control_ff;
      `ILC_IDX_TX_DEF_1: rd_byte = tx_code_def_1_ff;
      `ILC_IDX_TX_DEF_2: rd_byte = tx_code_def_2_ff;
      `ILC_IDX_UP_DEF_1: rd_byte = det_code_1_ff[0];
      `ILC_IDX_UP_DEF_2: rd_byte = det_code_2_ff[0];
      `ILC_IDX_DN_DEF_1: rd_byte = det_code_1_ff[1];
      `ILC_IDX_DN_DEF_2: rd_byte = det_code_2_ff[1];
      `ILC_IDX_SP_LEN: rd_byte = rx_spare_length_control_ff;
      `ILC_IDX_SP_DEF_1: rd_byte = det_code_1_ff[2];
      `ILC_IDX_SP_DEF_2: rd_byte = det_code_2_ff[2];
      `ILC_IDX_T1_CTRL: rd_byte = t1_common_control_1_ff;
      `ILC_IDX_MODE: rd_byte = mode_ctrl_ff;
      `ILC_IDX_STATUS_3: rd_byte = status_3;
      `ILC_IDX_IRQ_STAT: rd_byte = irq_stat_ff;
      `ILC_IDX_IRQ_EN: rd_byte = irq_en_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // one-cycle registered answer, ack drops the cycle after
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // transmit generator
  // ------------------------------------------------------------
  reg [4:0] tx_len;
  reg [4:0] tx_pos_ff;
  reg [7:0] frame_pos_ff;
  wire [15:0] tx_pattern = {tx_code_def_1_ff, tx_code_def_2_ff};
  wire [4:0] tx_pos_last = tx_len - 5'h01;
  wire [3:0] tx_bit_idx = 4'hF - tx_pos_ff[3:0];

  // length decode; 6 covers 3, 16 covers 8/4/2/1 with both bytes filled
  always @*
  begin
    case (inband_code_control_ff[`ILC_TX_LEN_HI:`ILC_TX_LEN_LO])
      2'h0: tx_len = `ILC_TX_LEN_5;
      2'h1: tx_len = `ILC_TX_LEN_6;
      2'h2: tx_len = `ILC_TX_LEN_7;
      default: tx_len = `ILC_LEN_LONG;
    endcase
  end

  // pattern bit per line bit, F-bit slot every 193 bits
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_pos_ff <= 5'h00;
      frame_pos_ff <= 8'h00;
      tx_data_o <= 1'b0;
      tx_code_active_o <= 1'b0;
    end
    else
    begin
      tx_code_active_o <= tx_enable;
      if (tx_bit_strobe_i)
      begin
        frame_pos_ff <= (frame_pos_ff == `ILC_FRAME_BITS - 8'h01) ? 8'h00
                        : frame_pos_ff + 8'h01;
        if (!tx_enable)
        begin
          tx_pos_ff <= 5'h00;
          tx_data_o <= tx_data_i;
        end
        else
        begin
          tx_pos_ff <= (tx_pos_ff >= tx_pos_last) ? 5'h00 : tx_pos_ff + 5'h01;
          if (fbit_ins && frame_pos_ff == 8'h00)
            tx_data_o <= tx_fbit_i;
          else
            tx_data_o <= tx_pattern[tx_bit_idx];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // receive detectors
  // ------------------------------------------------------------
  // true when the newest len bits of win are some rotation of the code
  function rot_match;
    input [15:0] win;
    input [15:0] code;
    input [4:0] len;
    integer r;
    integer i;
    integer j;
    reg ok;
    begin
      rot_match = 1'b0;
      for (r = 0; r < 16; r = r + 1)
      begin
        ok = (r < len);
        for (i = 0; i < 16; i = i + 1)
        begin
          j = r + i;
          if (j >= len)
            j = j - len;
          if (i < len && j < 16 && win[len - 1 - i] != code[15 - j])
            ok = 1'b0;
        end
        if (ok)
          rot_match = 1'b1;
      end
    end
  endfunction

  reg [15:0] rx_win_ff;
  reg [4:0] rx_fill_ff;

  // shared receive window, newest bit in bit 0
  always @(posedge clk_i)
  begin
    if (rst_i || !t1_mode)
    begin
      rx_win_ff <= 16'h0000;
      rx_fill_ff <= 5'h00;
    end
    else if (rx_bit_strobe_i)
    begin
      rx_win_ff <= {rx_win_ff[14:0], rx_data_i};
      rx_fill_ff <= (rx_fill_ff == `ILC_LEN_LONG) ? rx_fill_ff : rx_fill_ff + 5'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : det
      reg [22:0] time_ff;
      reg [22:0] bits_ff;
      reg [22:0] bad_ff;
      reg flag_ff;
      // one flag per detector, collected into a shared bus
      assign det_flag[g] = flag_ff;
      wire [4:0] len = (det_len_sel[g] == 3'h7) ? `ILC_LEN_LONG
                       : {2'h0, det_len_sel[g]} + 5'h01;
      // 16-bit code; short lengths use only the leading bits of byte one
      wire [15:0] code = {det_code_1_ff[g],
                          (len == `ILC_LEN_LONG) ? det_code_2_ff[g] : 8'h00};
      wire good = rot_match(rx_win_ff, code, len);
      wire period_end = (time_ff == INTEG_CYCLES - 1);
      // pass when fewer than a quarter of windows miss
      wire pass = (bits_ff != 23'h0) && (bad_ff < {2'h0, bits_ff[22:2]});

      // integration timer, bit and miss counts, flag decision
      always @(posedge clk_i)
      begin
        if (rst_i || !t1_mode || det_restart[g])
        begin
          time_ff <= 23'h0;
          bits_ff <= 23'h0;
          bad_ff <= 23'h0;
          if (rst_i || !t1_mode)
            flag_ff <= 1'b0;
        end
        else if (period_end)
        begin
          time_ff <= 23'h0;
          bits_ff <= 23'h0;
          bad_ff <= 23'h0;
          flag_ff <= pass;
        end
        else
        begin
          time_ff <= time_ff + 23'h1;
          if (rx_bit_strobe_i && rx_fill_ff >= len)
          begin
            bits_ff <= bits_ff + 23'h1;
            if (!good)
              bad_ff <= bad_ff + 23'h1;
          end
        end
      end
    end
  endgenerate

  // detected flags out, up/down/spare in bits 0/1/2
  always @(posedge clk_i)
  begin
    if (rst_i)
      code_detected_o <= 3'h0;
    else
      code_detected_o <= det_flag;
  end

endmodule

// file: ilc_defines.vh
// Purpose: constants for the in-band loop code generator and detector
// Assumes: register byte address is four times the register index
// Notes: definitions only
`ifndef ILC_DEFINES_VH
`define ILC_DEFINES_VH

// register indices (byte address = index * 4)
`define ILC_IDX_INBAND_CTRL 10'h0_0B6
`define ILC_IDX_TX_DEF_1 10'h0_0B7
`define ILC_IDX_TX_DEF_2 10'h0_0B8
`define ILC_IDX_UP_DEF_1 10'h0_0B9
`define ILC_IDX_UP_DEF_2 10'h0_0BA
`define ILC_IDX_DN_DEF_1 10'h0_0BB
`define ILC_IDX_DN_DEF_2 10'h0_0BC
`define ILC_IDX_SP_LEN 10'h0_0BD
`define ILC_IDX_SP_DEF_1 10'h0_0BE
`define ILC_IDX_SP_DEF_2 10'h0_0BF
`define ILC_IDX_T1_CTRL 10'h0_0C0
`define ILC_IDX_MODE 10'h0_0C1
`define ILC_IDX_STATUS_3 10'h0_0C2
`define ILC_IDX_IRQ_STAT 10'h0_0C3
`define ILC_IDX_IRQ_CLR 10'h0_0C4
`define ILC_IDX_IRQ_EN 10'h0_0C5

// field positions
`define ILC_TX_LEN_HI 7
`define ILC_TX_LEN_LO 6
`define ILC_UP_LEN_HI 5
`define ILC_UP_LEN_LO 3
`define ILC_DN_LEN_HI 2
`define ILC_DN_LEN_LO 0
`define ILC_SP_LEN_HI 2
`define ILC_SP_LEN_LO 0
`define ILC_TX_EN_BIT 0
`define ILC_T1_MODE_BIT 0
`define ILC_FBIT_INS_BIT 1
`define ILC_UP_FLAG_BIT 5
`define ILC_DN_FLAG_BIT 6
`define ILC_SP_FLAG_BIT 7

// reset values
`define ILC_RST_BYTE 8'h00
`define ILC_RST_MODE 8'h03

// timing
`define ILC_CLK_MHZ 125
`define ILC_INTEG_US 36000
`define ILC_FRAME_BITS 8'hC1
`define ILC_TX_LEN_5 5'h05
`define ILC_TX_LEN_6 5'h06
`define ILC_TX_LEN_7 5'h07
`define ILC_LEN_LONG 5'h10

`endif

// file: ilc_loop_code_checker.sv
// Purpose: bus, stream and flag checks for the loop code block
// Assumes: one clock, synchronous active high reset
// Notes: bound to every instance of the block
module ilc_loop_code_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire tx_bit_strobe_i,
  input wire tx_data_i,
  input wire tx_fbit_i,
  input wire tx_data_o,
  input wire tx_code_active_o,
  input wire [2:0] code_detected_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  chk_dat_upper: assert property (wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_tx_hold: assert property (!tx_bit_strobe_i |=> $stable(tx_data_o))
    else $error("transmit bit changed without strobe");
  chk_tx_pass: assert property ((tx_bit_strobe_i && !tx_code_active_o)
    ##1 !tx_code_active_o |-> tx_data_o == $past(tx_data_i))
    else $error("payload not passed while generator off");
  chk_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o &&
    code_detected_o == 3'h0 && !tx_code_active_o && !tx_data_o)
    else $error("outputs not cleared by reset");
  chk_flag_settle: assert property (!$stable(code_detected_o[0]) |=>
    $stable(code_detected_o[0]) [*8])
    else $error("up flag changed inside integration period");
endmodule

bind ilc_loop_code ilc_loop_code_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .tx_bit_strobe_i, .tx_data_i, .tx_fbit_i, .tx_data_o,
  .tx_code_active_o, .code_detected_o, .irq_o);

// file: ilc_line_model.sv
// Purpose: remote line equipment sending and taking loop codes
// Assumes: bit slots every cycle, or every other cycle when slow
// Notes: idle line carries random bits; sent code has rare bit errors
module ilc_line_model (
  input wire clk_i,
  input wire rst_i,
  input wire slow_i,
  input wire send_i,
  input wire [15:0] code_i,
  input wire [4:0] len_i,
  input wire tx_data_i,
  output logic tx_strobe_o,
  output logic rx_strobe_o,
  output logic rx_data_o,
  output logic [31:0] tx_hist_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 41;
  logic tick_ff;
  logic tx_q_ff;
  logic [4:0] pos_ff;
  wire slot = !rst_i && (!slow_i || tick_ff);

  // slot pacing and capture of sent bits
  always @(posedge clk_i)
  begin
    tick_ff <= rst_i ? 1'b0 : ~tick_ff;
    tx_strobe_o <= slot;
    rx_strobe_o <= slot;
    tx_q_ff <= tx_strobe_o;
    if (tx_q_ff)
      tx_hist_o <= {tx_hist_o[30:0], tx_data_i};
  end

  // code bits msb first over both bytes, about one flip in a hundred
  always @(posedge clk_i)
  begin
    if (rst_i || !send_i)
    begin
      pos_ff <= 5'h00;
      rx_data_o <= 1'($random(seed));
    end
    else if (slot)
    begin
      rx_data_o <= code_i[4'(15 - pos_ff)] ^ ($random(seed) % 100 == 0);
      pos_ff <= (pos_ff + 5'h01 == len_i) ? 5'h00 : pos_ff + 5'h01;
    end
  end
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the loop code block
// Assumes: short integration period, line model paces bit slots
// Notes: random codes from a fixed seed
`include "ilc_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INTEG = 2000;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tx_din = 0, tx_fbit = 0;
  logic slow = 0, send = 0, quiet = 0, ack, tx_stb, tx_dout, tx_act, rx_stb, rx_din, irq;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat_w = 32'h0000_0000, dat_r, hist;
  logic [15:0] mcode = 16'h0000;
  logic [4:0] mlen = 5'h01;
  logic [2:0] det_o;
  int seed = 41, err_total = 0, samples_checked = 0;

  ilc_loop_code #(.INTEG_CYCLES(INTEG)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .tx_bit_strobe_i(tx_stb),
    .tx_data_i(tx_din), .tx_fbit_i(tx_fbit), .tx_data_o(tx_dout), .tx_code_active_o(tx_act),
    .rx_bit_strobe_i(rx_stb), .rx_data_i(rx_din), .code_detected_o(det_o), .irq_o(irq));
  ilc_line_model i_line (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .send_i(send),
    .code_i(mcode), .len_i(mlen), .tx_data_i(tx_dout), .tx_strobe_o(tx_stb),
    .rx_strobe_o(rx_stb), .rx_data_o(rx_din), .tx_hist_o(hist));

  // ----------------------------------------
  // clock, payload stimulus, watchdog
  // ----------------------------------------
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    tx_din <= 1'($random(seed));
    tx_fbit <= quiet ? 1'b0 : 1'($random(seed));
  end
  initial
  begin
    repeat (80000) @(posedge clk_i);
    err_total++;
    complete_run();
  end

  // ----------------------------------------
  // tasks and expectation functions
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check(32'(ack), 32'h0000_0001);
    r = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    check(32'(r), 32'(e));
  endtask
  function automatic int tx_len(input int s);
    return (s == 3) ? 16 : 5 + s;
  endfunction
  function automatic logic tx_match(input logic [31:0] h, input logic [15:0] c, input int l);
    logic ok;
    for (int r = 0; r < l; r++)
    begin
      ok = 1'b1;
      for (int i = 0; i < 32; i++)
        if (h[31 - i] !== c[15 - ((i + r) % l)])
          ok = 1'b0;
      if (ok)
        return 1'b1;
    end
    return 1'b0;
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] c;
    int l, sel, d, n;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
      rdc(10'(`ILC_IDX_INBAND_CTRL + i), 8'h00);
    rdc(`ILC_IDX_MODE, 8'h03);
    for (int i = 0; i < 7; i++)
    begin
      c = 16'($random(seed));
      wr(10'(`ILC_IDX_INBAND_CTRL + i), c[7:0]);
      rdc(10'(`ILC_IDX_INBAND_CTRL + i), c[7:0]);
    end
    wr(10'h3FF, 8'hA5);
    rdc(10'h3FF, 8'h00);
    wr(`ILC_IDX_MODE, 8'h01);
    for (sel = 0; sel < 4; sel++)
    begin
      c = 16'($random(seed));
      slow <= sel[0];
      wr(`ILC_IDX_INBAND_CTRL, 8'(sel << 6));
      wr(`ILC_IDX_TX_DEF_1, c[15:8]);
      wr(`ILC_IDX_TX_DEF_2, c[7:0]);
      wr(`ILC_IDX_T1_CTRL, 8'h01);
      repeat (80) @(posedge clk_i);
      check(32'(tx_act), 32'h0000_0001);
      check(32'(tx_match(hist, c, tx_len(sel))), 32'h0000_0001);
      wr(`ILC_IDX_T1_CTRL, 8'h00);
      repeat (2) @(posedge clk_i);
      check(32'(tx_act), 32'h0000_0000);
    end
    slow <= 1'b0;
    quiet <= 1'b1;
    wr(`ILC_IDX_MODE, 8'h03);
    wr(`ILC_IDX_INBAND_CTRL, 8'hC0);
    wr(`ILC_IDX_TX_DEF_1, 8'hFF);
    wr(`ILC_IDX_TX_DEF_2, 8'hFF);
    wr(`ILC_IDX_T1_CTRL, 8'h01);
    repeat (20) @(posedge clk_i);
    n = 0;
    repeat (386)
    begin
      @(posedge clk_i);
      n += int'(tx_dout === 1'b0);
    end
    check(32'(n), 32'h0000_0002);
    quiet <= 1'b0;
    wr(`ILC_IDX_MODE, 8'h00);
    repeat (3) @(posedge clk_i);
    check(32'(tx_act), 32'h0000_0000);
    wr(`ILC_IDX_MODE, 8'h03);
    wr(`ILC_IDX_IRQ_EN, 8'hE0);
    // spare parked on a 16-bit all-zero code so it stays quiet
    wr(`ILC_IDX_SP_LEN, 8'h07);
    for (int k = 0; k < 6; k++)
    begin
      d = k % 3;
      l = (k < 2) ? 16 : 1 + int'($unsigned($random(seed)) % 7);
      c = 16'($random(seed));
      if (k == 1)
        c[7:0] = c[15:8];
      send <= 1'b0;
      repeat (2 * INTEG + 10) @(posedge clk_i);
      check(32'(det_o[d]), 32'h0000_0000);
      sel = (l == 16) ? 7 : l - 1;
      if (d == 2)
        wr(`ILC_IDX_SP_LEN, 8'(sel));
      else
        wr(`ILC_IDX_INBAND_CTRL, d ? 8'(sel) : 8'((sel << 3) | 7));
      wr(d == 2 ? `ILC_IDX_SP_DEF_2 : d ? `ILC_IDX_DN_DEF_2 : `ILC_IDX_UP_DEF_2,
        c[7:0]);
      mcode <= c;
      mlen <= 5'(l);
      send <= 1'b1;
      repeat (20) @(posedge clk_i);
      wr(d == 2 ? `ILC_IDX_SP_DEF_1 : d ? `ILC_IDX_DN_DEF_1 : `ILC_IDX_UP_DEF_1,
        c[15:8]);
      repeat (INTEG - 6) @(posedge clk_i);
      check(32'(det_o[d]), 32'h0000_0000);
      repeat (12) @(posedge clk_i);
      check(32'(det_o[d]), 32'h0000_0001);
      if (k == 0)
      begin
        rdc(`ILC_IDX_STATUS_3, 8'h20);
        rdc(`ILC_IDX_IRQ_STAT, 8'h20);
        wr(`ILC_IDX_IRQ_EN, 8'h00);
        repeat (2) @(posedge clk_i);
        check(32'(irq), 32'h0000_0000);
        wr(`ILC_IDX_IRQ_EN, 8'hE0);
        repeat (2) @(posedge clk_i);
        check(32'(irq), 32'h0000_0001);
        wr(`ILC_IDX_IRQ_CLR, 8'hFF);
        repeat (2) @(posedge clk_i);
        check(32'(irq), 32'h0000_0000);
        // later poll: code still present, flag must hold
        repeat (INTEG) @(posedge clk_i);
        rdc(`ILC_IDX_STATUS_3, 8'h20);
      end
    end
    wr(`ILC_IDX_MODE, 8'h00);
    repeat (3) @(posedge clk_i);
    check(32'(det_o), 32'h0000_0000);
    complete_run();
  end
endmodule
